// ### shared/dcrcl_pkg.sv
package dcrcl_pkg;
  localparam int         POS_W      = 16;
  localparam int         TIME_W     = 16;
  localparam int         REED_W     = 4;
  localparam int         CAP_DEPTH  = 8;
  localparam int         CAP_IDX_W  = 3;
  localparam int         VOTE_N     = 3;
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_STAT  = 8'h08;
  localparam logic [7:0] ADDR_REED  = 8'h0c;
  localparam logic [7:0] ADDR_CAP0  = 8'h10;
  localparam logic [7:0] ADDR_PERF  = 8'h30;
  localparam int         CTRL_CLR   = 0;
  localparam int         CTRL_MODE  = 1;
  localparam int         CTRL_CLRAL = 3;
  localparam int         CTRL_BYP   = 4;
  localparam logic [7:0] LIMIT_RST  = 8'h10;
  localparam logic [1:0] BYP_RST    = 2'h0;
  localparam logic [15:0] POS_TOL   = 16'h0004;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_MAN, MODE_SEMI, MODE_AUTO} dcrcl_mode_e;

  typedef struct packed {
    logic [POS_W-1:0] posA;
    logic [POS_W-1:0] posB;
    logic             extBlk;
  } dcrcl_chin_s;

  typedef struct packed {
    logic ins;
    logic wdr;
    logic blk;
    logic emg;
    logic busy;
  } dcrcl_chout_s;

  typedef struct packed {
    logic scramFollow;
    logic altInsReq;
    logic autoRunIn;
    logic pbRunIn1;
    logic pbRunIn2;
  } dcrcl_emg_s;

  typedef struct packed {
    logic ins;
    logic wdr;
  } dcrcl_opcmd_s;
endpackage

// ### logic/dcrcl_channel.sv
`timescale 1ns/1ps
module dcrcl_channel
  import dcrcl_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire dcrcl_chin_s  chIn,
  input  wire dcrcl_opcmd_s cmd,
  input  wire logic         emgReq,
  input  wire logic         motorStat,
  output dcrcl_chout_s      chOut
);
  logic [POS_W-1:0] posDiff;
  logic             posBad;
  dcrcl_chout_s     chOut_ff;

  // both converter values are used; a spread above POS_TOL between them blocks this channel
  always_comb
  begin
    posDiff = (chIn.posA > chIn.posB) ? chIn.posA - chIn.posB : chIn.posB - chIn.posA; // RL11
    posBad  = posDiff > POS_TOL; // RL10
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      chOut_ff <= '0;
    end
    else
    begin
      chOut_ff.blk  <= chIn.extBlk | posBad; // RL4
      chOut_ff.ins  <= cmd.ins & ~cmd.wdr;
      chOut_ff.wdr  <= cmd.wdr & ~cmd.ins;
      chOut_ff.emg  <= emgReq;
      chOut_ff.busy <= motorStat; // RL14
    end
  end

  assign chOut = chOut_ff;
endmodule

// ### logic/dcrcl_top.sv
// Operation
// [RL1] two channels, own inputs, outputs compared
// [RL2] act only when both channels agree
// [RL3] sustained disagreement raises rod block
// [RL4] one channel alone may raise block
// [RL5] motor emergency vote is three of three
// [RL6] alternate insertion enables one vote bypass
// [RL7] normal moves independent of scram valves
// [RL8] selector gives control to one interface
// [RL9] backup interface shows same, controls when selected
// [RL10] two converters give two position values
// [RL11] each channel uses both position values
// [RL12] motor on/off, phase swap sets direction
// [RL13] built-in brake drops promptly after motor off
// [RL14] motor executes commands, returns status
// [RL15] discrete emergency input drives insertion
// [RL16] holding brake on command, two status bits
// [RL17] control panel ors scram, network, pushbuttons
// [RL18] field panel forwards emergency to motors
// [RL19] recorder forwards reed switch status
// [RL20] scram start arms time-tagged change capture
// [RL21] analysis result passed to plant network
// [RL22] blocks never inhibit emergency insertion
// [RL23] sequence violation forces manual or alarms
// [RL24] disagreement latched after configurable count
// [RL25] channel logic in separate hardware
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module dcrcl_top
  import dcrcl_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [7:0]       awaddr,
  input  wire logic             awvalid,
  output logic                  awready,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output logic                  wready,
  output logic [1:0]            bresp,
  output logic                  bvalid,
  input  wire logic             bready,
  input  wire logic [7:0]       araddr,
  input  wire logic             arvalid,
  output logic                  arready,
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  rvalid,
  input  wire logic             rready,
  input  wire dcrcl_pkg::dcrcl_chin_s  chInA,
  input  wire dcrcl_pkg::dcrcl_chin_s  chInB,
  input  wire dcrcl_pkg::dcrcl_opcmd_s opMain,
  input  wire dcrcl_pkg::dcrcl_opcmd_s opBackup,
  input  wire logic             opSelBackup,
  input  wire dcrcl_pkg::dcrcl_emg_s   emgIn,
  input  wire logic             seqViol,
  input  wire logic             scramTestStart,
  input  wire logic             fullScram,
  input  wire logic [dcrcl_pkg::REED_W-1:0] reedSw,
  output logic                  motorOn,
  output logic                  phaseSwap,
  output logic                  brakeEnergize,
  output logic                  holdBrakeRel,
  output logic                  holdBrakeStatA,
  output logic                  holdBrakeStatB,
  output logic                  rodBlock,
  output logic                  fieldEmg,
  output logic                  seqAlarm,
  output logic                  activeBackup,
  output logic [dcrcl_pkg::REED_W-1:0] reedFwd,
  output logic                  perfValid,
  output logic [dcrcl_pkg::TIME_W-1:0] perfTime
);
  localparam int CAP_W = REED_W + TIME_W;

  dcrcl_opcmd_s        opSel;
  dcrcl_chout_s        chOutA;
  dcrcl_chout_s        chOutB;
  logic                disagree;
  logic                agree;
  logic [7:0]          disCnt_ff;
  logic [7:0]          limit_ff;
  logic                blkLatch_ff;
  logic                clrBlk;
  logic                clrAlarm;
  dcrcl_mode_e         mode_ff;
  logic [1:0]          bypSel_ff;
  logic                ctrlEmg_ff;
  logic                fieldEmg_ff;
  logic [VOTE_N-1:0]   votes;
  logic [VOTE_N-1:0]   votesEff;
  logic                emgIns_ff;
  logic                moveIns;
  logic                moveWdr;
  logic                nxt_motorOn;
  logic                motorOn_ff;
  logic                phaseSwap_ff;
  logic                brkEn_ff;
  logic                hbRel_ff;
  logic                hbStatA_ff;
  logic                hbStatB_ff;
  logic                rodBlock_ff;
  logic                seqAlarm_ff;
  logic                actBkp_ff;
  logic [REED_W-1:0]   reedFwd_ff;
  logic [REED_W-1:0]   reedPrev_ff;
  logic                armed_ff;
  logic [TIME_W-1:0]   timer_ff;
  logic [CAP_W-1:0]    capMem_ff [CAP_DEPTH];
  logic [CAP_IDX_W:0]  capCnt_ff;
  logic                perfValid_ff;
  logic [TIME_W-1:0]   perfTime_ff;
  logic                awready_ff;
  logic                wready_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                arready_ff;
  logic                rvalid_ff;
  logic [1:0]          rresp_ff;
  logic [31:0]         rdata_ff;
  logic                wrCtrl;
  logic                wrLimit;
  logic [31:0]         rdMux;
  logic                rdHit;
  logic [7:0]          capOff;

  // the selector is a hardwired pin; only the chosen interface steers moves
  assign opSel = opSelBackup ? opBackup : opMain; // RL8 RL9

  // separate instances so a fault in one channel cannot reach the other
  dcrcl_channel u_chanA ( // RL25 RL1
    .sys_clk   (sys_clk),
    .srst      (srst),
    .chIn      (chInA),
    .cmd       (opSel),
    .emgReq    (fieldEmg_ff),
    .motorStat (motorOn_ff),
    .chOut     (chOutA)
  );

  dcrcl_channel u_chanB (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .chIn      (chInB),
    .cmd       (opSel),
    .emgReq    (fieldEmg_ff),
    .motorStat (motorOn_ff),
    .chOut     (chOutB)
  );

  assign disagree = chOutA != chOutB; // RL1
  assign agree    = ~disagree;

  // momentary skew between channels is tolerated for one cycle less than the limit count
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      disCnt_ff <= 8'h00;
    end
    else if (!disagree)
    begin
      disCnt_ff <= 8'h00;
    end
    else if (disCnt_ff != 8'hff)
    begin
      disCnt_ff <= disCnt_ff + 8'h01; // RL24
    end
  end

  // set wins over software clear so a disagreement is never lost
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      blkLatch_ff <= 1'b0;
    end
    else if (disagree && (9'(disCnt_ff) + 9'h001 >= 9'(limit_ff)))
    begin
      blkLatch_ff <= 1'b1; // RL3 RL24
    end
    else if (clrBlk)
    begin
      blkLatch_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rodBlock_ff <= 1'b0;
    end
    else
    begin
      rodBlock_ff <= blkLatch_ff | chOutA.blk | chOutB.blk; // RL4
    end
  end

  // emergency chain: control panel then field panel, each a registered stage
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctrlEmg_ff  <= 1'b0;
      fieldEmg_ff <= 1'b0;
    end
    else
    begin
      ctrlEmg_ff  <= |emgIn; // RL17
      fieldEmg_ff <= ctrlEmg_ff; // RL18
    end
  end

  assign votes = {chOutB.emg, chOutA.emg, fieldEmg_ff}; // RL15

  // alternate insertion lets at most one leg of the vote, the one bypSel_ff selects, be bypassed
  generate
    for (genvar v = 0; v < VOTE_N; v++)
    begin : g_vote
      assign votesEff[v] = votes[v] | (emgIn.altInsReq && bypSel_ff == 2'(v)); // RL6
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      emgIns_ff <= 1'b0;
    end
    else
    begin
      emgIns_ff <= &votesEff; // RL5
    end
  end

  // normal moves never look at scram valve signals, only channel outputs
  assign moveIns = agree && chOutA.ins && !rodBlock_ff; // RL2 RL7
  assign moveWdr = agree && chOutA.wdr && !rodBlock_ff; // RL2 RL7
  assign nxt_motorOn = emgIns_ff | moveIns | moveWdr; // RL22 RL14

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      motorOn_ff   <= 1'b0;
      phaseSwap_ff <= 1'b0;
    end
    else
    begin
      motorOn_ff   <= nxt_motorOn; // RL12
      phaseSwap_ff <= moveWdr && !emgIns_ff; // RL12
    end
  end

  // brake held released one cycle past motor off, never longer
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      brkEn_ff <= 1'b0;
    end
    else
    begin
      brkEn_ff <= nxt_motorOn | motorOn_ff; // RL13
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      hbRel_ff   <= 1'b0;
      hbStatA_ff <= 1'b0;
      hbStatB_ff <= 1'b0;
    end
    else
    begin
      hbRel_ff   <= nxt_motorOn; // RL16
      hbStatA_ff <= hbRel_ff; // RL16
      hbStatB_ff <= hbRel_ff; // RL16
    end
  end

  // hardware forcing to manual beats a same-cycle software mode write
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      mode_ff   <= MODE_MAN;
      bypSel_ff <= BYP_RST;
      limit_ff  <= LIMIT_RST;
    end
    else
    begin
      if (seqViol && mode_ff != MODE_MAN)
      begin
        mode_ff <= MODE_MAN; // RL23
      end
      else if (wrCtrl)
      begin
        unique case (wdata[CTRL_MODE+:2])
          2'h1:    mode_ff <= MODE_SEMI;
          2'h2:    mode_ff <= MODE_AUTO;
          default: mode_ff <= MODE_MAN;
        endcase
      end
      if (wrCtrl)
      begin
        bypSel_ff <= wdata[CTRL_BYP+:2];
      end
      if (wrLimit)
      begin
        limit_ff <= wdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      seqAlarm_ff <= 1'b0;
    end
    else if (seqViol && mode_ff == MODE_MAN)
    begin
      seqAlarm_ff <= 1'b1; // RL23
    end
    else if (clrAlarm)
    begin
      seqAlarm_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      actBkp_ff <= 1'b0;
    end
    else
    begin
      actBkp_ff <= opSelBackup; // RL8
    end
  end

  // capture stops when full so early changes survive; later ones are dropped
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      reedFwd_ff   <= '0;
      reedPrev_ff  <= '0;
      armed_ff     <= 1'b0;
      timer_ff     <= '0;
      capCnt_ff    <= '0;
      perfValid_ff <= 1'b0;
      perfTime_ff  <= '0;
    end
    else
    begin
      reedFwd_ff   <= reedSw; // RL19
      reedPrev_ff  <= reedSw;
      perfValid_ff <= 1'b0;
      if ((scramTestStart || fullScram) && !armed_ff)
      begin
        armed_ff  <= 1'b1; // RL20
        timer_ff  <= '0;
        capCnt_ff <= '0;
      end
      else if (armed_ff)
      begin
        timer_ff <= timer_ff + 16'h0001;
        if (reedSw != reedPrev_ff)
        begin
          capMem_ff[capCnt_ff[CAP_IDX_W-1:0]] <= {reedSw, timer_ff}; // RL20
          capCnt_ff <= capCnt_ff + 4'h1;
          if (capCnt_ff == 4'(CAP_DEPTH - 1))
          begin
            armed_ff     <= 1'b0;
            perfValid_ff <= 1'b1; // RL21
            perfTime_ff  <= timer_ff;
          end
        end
      end
    end
  end

  // register bus: address and data taken together, one write at a time; reads run on their own channel
  assign wrCtrl   = awready_ff && awaddr == ADDR_CTRL && wstrb[0];
  assign wrLimit  = awready_ff && awaddr == ADDR_LIMIT && wstrb[0];
  assign clrBlk   = wrCtrl && wdata[CTRL_CLR];
  assign clrAlarm = wrCtrl && wdata[CTRL_CLRAL];

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end
    else
    begin
      awready_ff <= awvalid && wvalid && !awready_ff && !bvalid_ff;
      wready_ff  <= awvalid && wvalid && !awready_ff && !bvalid_ff;
      if (awready_ff)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (awaddr == ADDR_CTRL || awaddr == ADDR_LIMIT) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // entries start at the base offset, so the index counts from there
  assign capOff = araddr - ADDR_CAP0;

  always_comb
  begin
    rdMux = 32'h0;
    rdHit = 1'b1;
    unique case (araddr)
      ADDR_CTRL:  rdMux = {26'h0, bypSel_ff, 1'b0, mode_ff, 1'b0};
      ADDR_LIMIT: rdMux = {24'h0, limit_ff};
      ADDR_STAT:  rdMux = {20'h0, capCnt_ff, armed_ff, actBkp_ff, seqAlarm_ff,
                           blkLatch_ff, chOutB.blk, chOutA.blk, motorOn_ff, emgIns_ff};
      ADDR_REED:  rdMux = {28'h0, reedFwd_ff};
      ADDR_PERF:  rdMux = {16'h0, perfTime_ff};
      default:
      begin
        if (araddr >= ADDR_CAP0 && araddr < ADDR_PERF && araddr[1:0] == 2'h0)
        begin
          rdMux = {12'h0, capMem_ff[capOff[CAP_IDX_W+1:2]]}; // RL20
        end
        else
        begin
          rdHit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= 32'h0;
    end
    else
    begin
      arready_ff <= arvalid && !arready_ff && !rvalid_ff;
      if (arready_ff)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rdMux;
        rresp_ff  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready)
      begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign awready        = awready_ff;
  assign wready         = wready_ff;
  assign bvalid         = bvalid_ff;
  assign bresp          = bresp_ff;
  assign arready        = arready_ff;
  assign rvalid         = rvalid_ff;
  assign rresp          = rresp_ff;
  assign rdata          = rdata_ff;
  assign motorOn        = motorOn_ff;
  assign phaseSwap      = phaseSwap_ff;
  assign brakeEnergize  = brkEn_ff;
  assign holdBrakeRel   = hbRel_ff;
  assign holdBrakeStatA = hbStatA_ff;
  assign holdBrakeStatB = hbStatB_ff;
  assign rodBlock       = rodBlock_ff;
  assign fieldEmg       = fieldEmg_ff;
  assign seqAlarm       = seqAlarm_ff;
  assign activeBackup   = actBkp_ff;
  assign reedFwd        = reedFwd_ff;
  assign perfValid      = perfValid_ff;
  assign perfTime       = perfTime_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_latch_set;
    disagree && (9'(disCnt_ff) + 9'h001 >= 9'(limit_ff)) |=> blkLatch_ff;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("block not latched"); // RL3

  property p_latch_hold;
    blkLatch_ff && !clrBlk |=> blkLatch_ff;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched block lost"); // RL24

  property p_single_blk;
    chOutA.blk || chOutB.blk |=> rodBlock_ff;
  endproperty
  a_single_blk: assert property (p_single_blk) else $error("single channel block ignored"); // RL4

  property p_agree_only;
    disagree && !emgIns_ff |=> !motorOn_ff;
  endproperty
  a_agree_only: assert property (p_agree_only) else $error("move on disagreement"); // RL2

  property p_emg_override;
    emgIns_ff |=> motorOn_ff && !phaseSwap_ff;
  endproperty
  a_emg_override: assert property (p_emg_override) else $error("emergency insertion inhibited"); // RL22

  property p_vote;
    $rose(emgIns_ff) |-> $past(&votesEff) && ($past(&votes) || $past(emgIn.altInsReq));
  endproperty
  a_vote: assert property (p_vote) else $error("vote not three of three"); // RL5

  property p_brake;
    $fell(motorOn_ff) |-> brkEn_ff ##1 (!brkEn_ff || motorOn_ff);
  endproperty
  a_brake: assert property (p_brake) else $error("brake not dropped after motor off"); // RL13

  property p_emg_chain;
    (|emgIn) |-> ##2 fieldEmg_ff;
  endproperty
  a_emg_chain: assert property (p_emg_chain) else $error("field panel not driven"); // RL18

  property p_seq_manual;
    seqViol && mode_ff != MODE_MAN |=> mode_ff == MODE_MAN;
  endproperty
  a_seq_manual: assert property (p_seq_manual) else $error("manual mode not forced"); // RL23

  c_latch: cover property ($rose(blkLatch_ff));
  c_emg: cover property ($rose(emgIns_ff) ##1 motorOn_ff);
  c_cap_full: cover property (perfValid_ff);
  c_alarm: cover property ($rose(seqAlarm_ff));
endmodule

// ### testbench/dcrcl_drive_model.sv
`timescale 1ns/1ps
module dcrcl_drive_model
  import dcrcl_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire logic                    motorOn,
  input  wire logic                    phaseSwap,
  input  wire logic [dcrcl_pkg::POS_W-1:0] offsetB,
  output logic [dcrcl_pkg::POS_W-1:0]  posA,
  output logic [dcrcl_pkg::POS_W-1:0]  posB
);
  logic [POS_W-1:0] rodPos_ff;

  // rod moves one step per powered cycle; direction comes from the phase order
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rodPos_ff <= 16'h8000;
    else if (motorOn)
      rodPos_ff <= phaseSwap ? rodPos_ff + 16'h0001 : rodPos_ff - 16'h0001;
  end

  // two converters watch one rod; offsetB models a drifting second converter
  assign posA = rodPos_ff;
  assign posB = rodPos_ff + offsetB;
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dcrcl_pkg::*;
  logic          sys_clk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic          awready, wready, bvalid, arready, rvalid, perfValid;
  logic [7:0]    awaddr, araddr;
  logic [31:0]   wdata, rdata;
  logic [1:0]    bresp, rresp;
  logic          motorOn, phaseSwap, brakeEnergize, holdBrakeRel, holdBrakeStatA, holdBrakeStatB;
  logic          rodBlock, fieldEmg, seqAlarm, activeBackup, opSelBackup, seqViol, scramTestStart, extA, fullScram;
  logic [3:0]    reedSw, reedFwd;
  logic [15:0]   perfTime, pA, pB, offB;
  dcrcl_chin_s   chInA, chInB;
  dcrcl_opcmd_s  opMain, opBackup;
  dcrcl_emg_s    emgIn;
  logic [5:0]    drv;
  logic [3:0]    flg;
  int            mismatches = 0;
  int            compares = 0;
  int            perfSeen = 0;

  assign chInA = '{posA: pA, posB: pB, extBlk: extA};
  assign chInB = '{posA: pA, posB: pB, extBlk: 1'b0};
  assign drv = {motorOn, phaseSwap, brakeEnergize, holdBrakeRel, holdBrakeStatA, holdBrakeStatB};
  assign flg = {rodBlock, fieldEmg, seqAlarm, activeBackup};

  dcrcl_top i_dcrcl_top (.sys_clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .chInA, .chInB, .opMain, .opBackup, .opSelBackup, .emgIn, .seqViol, .scramTestStart,
    .fullScram, .reedSw, .motorOn, .phaseSwap, .brakeEnergize, .holdBrakeRel, .holdBrakeStatA,
    .holdBrakeStatB, .rodBlock, .fieldEmg, .seqAlarm, .activeBackup, .reedFwd, .perfValid, .perfTime);

  dcrcl_drive_model i_dcrcl_drive_model (.sys_clk, .srst, .motorOn, .phaseSwap, .offsetB(offB),
    .posA(pA), .posB(pB));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // pulse is one cycle wide, so count it at every edge
  always @(posedge sys_clk)
    if (perfValid === 1'b1)
      perfSeen++;

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tmo();
    mismatches++;
    $display("[FAIL] handshake expected answer seen timeout");
    test_done();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (awready !== 1'b1 && n < 64);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1 && n < 64)
    begin
      @(posedge sys_clk);
      n++;
    end
    r = bresp;
    bready <= 1'b0;
    @(posedge sys_clk);
    if (n >= 64)
      tmo();
    chk("bresp", 32'(r), 32'(er));
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (arready !== 1'b1 && n < 64);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < 64)
    begin
      @(posedge sys_clk);
      n++;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge sys_clk);
    if (n >= 64)
      tmo();
    chk("rdata", d & m, e);
    chk("rresp", 32'(r), 32'(er));
  endtask

  task automatic t_reset();
    chk("drive", 32'(drv), 32'h0);
    chk("flags", 32'(flg), 32'h0);
    axr(ADDR_CTRL, 32'h36, 32'h0, RESP_OKAY);
    axr(ADDR_LIMIT, 32'hff, 32'(LIMIT_RST), RESP_OKAY);
    axr(8'h40, 32'hffffffff, 32'h0, RESP_SLVERR);
    axw(ADDR_STAT, 32'h1, RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic t_move();
    opBackup <= 2'b10;
    cyc(5);
    chk("drive", 32'(drv), 32'h0);
    opBackup <= 2'b00;
    opMain <= 2'b10;
    cyc(5);
    chk("drive", 32'(drv), 32'h2f);
    opMain <= 2'b01;
    cyc(5);
    chk("drive", 32'(drv), 32'h3f);
    opMain <= 2'b00;
    cyc(5);
    chk("drive", 32'(drv), 32'h0);
    opSelBackup <= 1'b1;
    opMain <= 2'b10;
    cyc(5);
    chk("drive", 32'(drv), 32'h0);
    chk("flags", 32'(flg), 32'h1);
    opMain <= 2'b00;
    opBackup <= 2'b01;
    cyc(5);
    chk("drive", 32'(drv), 32'h3f);
    opBackup <= 2'b00;
    opSelBackup <= 1'b0;
    cyc(5);
    $display("test move done");
  endtask

  task automatic t_block();
    axw(ADDR_LIMIT, 32'h3, RESP_OKAY);
    extA <= 1'b1;
    cyc(1);
    extA <= 1'b0;
    cyc(6);
    axr(ADDR_STAT, 32'h10, 32'h0, RESP_OKAY);
    extA <= 1'b1;
    cyc(8);
    chk("flags", 32'(flg), 32'h8);
    axr(ADDR_STAT, 32'h1c, 32'h14, RESP_OKAY);
    extA <= 1'b0;
    opMain <= 2'b10;
    cyc(6);
    chk("drive", 32'(drv), 32'h0);
    chk("flags", 32'(flg), 32'h8);
    opMain <= 2'b00;
    axw(ADDR_CTRL, 32'h1, RESP_OKAY);
    cyc(4);
    chk("flags", 32'(flg), 32'h0);
    offB <= 16'h0004;
    cyc(6);
    chk("flags", 32'(flg), 32'h0);
    offB <= 16'h0005;
    cyc(6);
    chk("flags", 32'(flg), 32'h8);
    axr(ADDR_STAT, 32'h1c, 32'h0c, RESP_OKAY);
    $display("test block done");
  endtask

  // rod block stays on here so every insertion path runs past it
  task automatic t_emg();
    for (int k = 0; k < 5; k++)
    begin
      emgIn <= dcrcl_emg_s'(5'h01 << k);
      cyc(8);
      chk("emgFlags", 32'(flg), 32'hc);
      chk("emgDrive", 32'(drv[5:4]), 32'h2);
      emgIn <= '0;
      cyc(8);
      chk("emgIdle", 32'(drv[5]), 32'h0);
    end
    offB <= 16'h0000;
    cyc(6);
    $display("test emergency done");
  endtask

  task automatic t_seq();
    axw(ADDR_CTRL, 32'h2, RESP_OKAY);
    axr(ADDR_CTRL, 32'h36, 32'h2, RESP_OKAY);
    seqViol <= 1'b1;
    cyc(1);
    seqViol <= 1'b0;
    cyc(4);
    axr(ADDR_CTRL, 32'h36, 32'h0, RESP_OKAY);
    axw(ADDR_CTRL, 32'h4, RESP_OKAY);
    axr(ADDR_CTRL, 32'h36, 32'h4, RESP_OKAY);
    seqViol <= 1'b1;
    cyc(1);
    seqViol <= 1'b0;
    cyc(4);
    axr(ADDR_CTRL, 32'h36, 32'h0, RESP_OKAY);
    chk("flags", 32'(flg), 32'h0);
    seqViol <= 1'b1;
    cyc(1);
    seqViol <= 1'b0;
    cyc(4);
    chk("flags", 32'(flg), 32'h2);
    axw(ADDR_CTRL, 32'h8, RESP_OKAY);
    cyc(3);
    chk("flags", 32'(flg), 32'h0);
    axw(ADDR_CTRL, 32'h16, RESP_OKAY);
    axr(ADDR_CTRL, 32'h36, 32'h10, RESP_OKAY);
    axw(ADDR_CTRL, 32'h0, RESP_OKAY);
    $display("test sequence done");
  endtask

  task automatic t_rec();
    scramTestStart <= 1'b1;
    cyc(1);
    scramTestStart <= 1'b0;
    for (int k = 1; k <= 8; k++)
    begin
      reedSw <= 4'(k);
      cyc(3);
    end
    cyc(4);
    chk("reedFwd", 32'(reedFwd), 32'h8);
    chk("perfPulses", 32'(perfSeen), 32'h1);
    // changes come three cycles apart, first one tagged at time zero
    chk("perfTime", 32'(perfTime), 32'h15);
    axr(ADDR_CAP0, 32'hfffff, 32'h10000, RESP_OKAY);
    axr(ADDR_CAP0 + 8'h1c, 32'hfffff, 32'h80015, RESP_OKAY);
    axr(ADDR_PERF, 32'hffff, 32'h15, RESP_OKAY);
    axr(ADDR_STAT, 32'h80, 32'h0, RESP_OKAY);
    reedSw <= 4'h0;
    cyc(6);
    chk("perfPulses", 32'(perfSeen), 32'h1);
    // a full-core scram arms capture as well
    fullScram <= 1'b1;
    cyc(1);
    fullScram <= 1'b0;
    reedSw <= 4'h3;
    cyc(3);
    axr(ADDR_STAT, 32'hf80, 32'h180, RESP_OKAY);
    $display("test recorder done");
  endtask

  initial
  begin
    srst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {opMain, opBackup, opSelBackup, emgIn, seqViol, scramTestStart, fullScram, extA, reedSw, offB} = '0;
    cyc(4);
    srst <= 1'b0;
    cyc(1);
    t_reset();
    t_move();
    t_block();
    t_emg();
    t_seq();
    t_rec();
    test_done();
  end
endmodule
